// ---- motion_set_pkg.sv ----
// constants and types shared by the motion set sequencer
package motion_set_pkg;
    localparam int POS_W = 32;
    localparam int SET_W = 5;
    localparam int SETS = 32;
    // control word 1 bit positions
    localparam int CW1_ENERGIZE = 2;
    localparam int CW1_STOP_N = 4;
    localparam int CW1_START = 6;
    localparam int CW1_ACK = 7;
    localparam int CW1_GUIDE = 10;
    // status word 1 bit positions
    localparam int SW1_NO_ERROR = 3;
    localparam int SW1_REACHED = 10;
    localparam int SW1_MARK_SEEN = 15;
    // status word 2 fields
    localparam int SW2_SET_LSB = 0;
    localparam int SW2_FLAG_LSB = 12;
    // table row field layout
    localparam int ROW_W = 48;
    localparam int ROW_TGT_LSB = 0;
    localparam int ROW_FUNC_LSB = 32;
    localparam int ROW_FLAG_LSB = 35;
    localparam int ROW_DIR_LSB = 41;
    localparam int ROW_HIDEC_BIT = 44;
    localparam logic [ROW_W-1:0] ROW_RESET = 48'h0000_0000_0000;
    localparam logic [SET_W-1:0] HOMING_SET = 5'h00;
    typedef enum logic [2:0] {
        FN_EMPTY = 3'h0, FN_ABS = 3'h1, FN_REL = 3'h2, FN_GEAR = 3'h3,
        FN_SEARCH = 3'h4, FN_VEL = 3'h5, FN_STOP = 3'h6
    } set_func_t;
    typedef enum logic [2:0] {
        DIR_ANY = 3'h0, DIR_POS = 3'h1, DIR_NEG = 3'h2, DIR_SHORT = 3'h3, DIR_KEEP = 3'h4
    } dir_policy_t;
    // flag codes: 00 and 11 leave unchanged, 10 clears, 01 sets
    localparam logic [1:0] FLAG_CLR = 2'h2;
    localparam logic [1:0] FLAG_SET = 2'h1;
endpackage : motion_set_pkg

// ---- motion_set_sequencer.sv ----
// command arbitration, set table sequencing and mark window logic
`timescale 1ns/1ps
// Overview of operation
// - guided: energize only when enable input and control bit 2 both high
// - guided: acknowledge only from control bit 7, enable input ignored
// - guided: jog inputs have no effect
// - unguided: control word ignored for these outputs, pins drive energize, ack, stop, jog
// - status updated always; outputs mirror status 1 bits 3 and 10
// - modulo absolute moves: any, positive, negative, shortest, keep direction
// - dynamic positioning decides direction from predicted braking position
// - direction policy bypassed for negative targets or targets at reset distance
// - no direction policy for test moves or post-homing positioning
// - marks ignored while position inside absolute ignore window
// - one shared ignore window for all mark sets
// - offset move unreachable without higher deceleration raises error
// - with higher deceleration allowed, device picks jerk and deceleration
// - mark taken from mark input, reported on status 1 bit 15
// - table holds homing row plus 31 motion rows
// - set number taken from second control word field
// - functions: empty, abs, rel, gearing, search, velocity, stop
// - start with set zero runs homing
// - after a set other than homing ends update flags bits 12 to 14 of status 2
// - per flag code: unchanged, clear, or set and drive output high
module motion_set_sequencer
    import motion_set_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic [15:0]       ctrl_word1_i,
    input  wire logic [15:0]       ctrl_word2_i,
    input  wire logic              enable_ack_input_i,
    input  wire logic              stop_request_input_i,
    input  wire logic              jog_plus_input_i,
    input  wire logic              jog_minus_input_i,
    input  wire logic              mark_input_i,
    input  wire logic              held_at_zero_i,
    input  wire logic              fault_i,
    input  wire logic              motion_done_i,
    input  wire logic              test_move_i,
    input  wire logic              post_homing_i,
    input  wire logic              dynamic_pos_i,
    input  wire logic [POS_W-1:0]  actual_pos_i,
    input  wire logic [POS_W-1:0]  brake_pos_i,
    input  wire logic [POS_W-1:0]  travel_dir_neg_i,
    input  wire logic              decel_short_i,
    input  wire logic [POS_W-1:0]  reset_dist_i,
    input  wire logic [POS_W-1:0]  ignore_zone_begin_i,
    input  wire logic [POS_W-1:0]  ignore_zone_end_i,
    input  wire logic              tbl_we_i,
    input  wire logic [SET_W-1:0]  tbl_addr_i,
    input  wire logic [ROW_W-1:0]  tbl_wdata_i,
    output logic                   energize_o,
    output logic                   ack_o,
    output logic                   stop_o,
    output logic                   jog_plus_o,
    output logic                   jog_minus_o,
    output logic                   no_error_output_o,
    output logic                   target_reached_output_o,
    output logic                   held_at_zero_output_o,
    output logic [15:0]            status_word1_o,
    output logic [15:0]            status_word2_o,
    output logic [2:0]             programmable_set_flags_o,
    output logic                   homing_start_o,
    output logic                   move_start_o,
    output logic [2:0]             move_func_o,
    output logic [POS_W-1:0]       move_target_o,
    output logic                   move_dir_neg_o,
    output logic                   move_dir_free_o,
    output logic                   hi_decel_o,
    output logic                   mark_error_o
);

    // pin synchronisers; first stage only feeds the second
    logic [4:0] pin_s1_q;
    logic [4:0] pin_s2_q;
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pin_s1_q <= 5'h00;
            pin_s2_q <= 5'h00;
        end
        else
        begin
            pin_s1_q <= {mark_input_i, jog_minus_input_i, jog_plus_input_i,
                         stop_request_input_i, enable_ack_input_i};
            pin_s2_q <= pin_s1_q;
        end
    end
    logic en_s, stopin_s, jp_s, jm_s, mark_s;
    assign en_s     = pin_s2_q[0];
    assign stopin_s = pin_s2_q[1];
    assign jp_s     = pin_s2_q[2];
    assign jm_s     = pin_s2_q[3];
    assign mark_s   = pin_s2_q[4];

    logic guided;
    assign guided = ctrl_word1_i[CW1_GUIDE];

    logic ack_prev_q;
    logic ack_src;
    assign ack_src = guided ? ctrl_word1_i[CW1_ACK] : en_s;

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            energize_o  <= 1'b0;
            stop_o      <= 1'b1;
            jog_plus_o  <= 1'b0;
            jog_minus_o <= 1'b0;
            ack_o       <= 1'b0;
            ack_prev_q  <= 1'b0;
        end
        else
        begin
            ack_prev_q <= ack_src;
            ack_o      <= ack_src & ~ack_prev_q;
            if (guided)
            begin
                energize_o  <= en_s & ctrl_word1_i[CW1_ENERGIZE];
                stop_o      <= ~stopin_s | ~ctrl_word1_i[CW1_STOP_N];
                jog_plus_o  <= 1'b0;
                jog_minus_o <= 1'b0;
            end
            else
            begin
                energize_o  <= en_s;
                stop_o      <= ~stopin_s;
                jog_plus_o  <= jp_s & ~jm_s;
                jog_minus_o <= jm_s & ~jp_s;
            end
        end
    end

    // set table, row 0 is homing
    logic [ROW_W-1:0] table_q [SETS];
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            for (int i = 0; i < SETS; i++)
                table_q[i] <= ROW_RESET;
        end
        else if (tbl_we_i)
        begin
            table_q[tbl_addr_i] <= tbl_wdata_i;
        end
    end

    // start edge and set latch
    logic start_prev_q;
    logic start_rise;
    logic [SET_W-1:0] set_q;
    assign start_rise = ctrl_word1_i[CW1_START] & ~start_prev_q;

    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0001,
        ST_RUN    = 4'b0010,
        ST_SEARCH = 4'b0100,
        ST_OFFSET = 4'b1000
    } seq_state_t;
    seq_state_t state_q;

    logic [ROW_W-1:0] row_cur;
    assign row_cur = table_q[set_q];
    logic [2:0] func_cur;
    assign func_cur = row_cur[ROW_FUNC_LSB +: 3];

    // next row slot for the offset move that follows a search
    function automatic logic [SET_W-1:0] next_set(input logic [SET_W-1:0] s);
        next_set = s + 5'h01;
    endfunction : next_set

    // signed window test, bounds are absolute positions
    function automatic logic in_zone(input logic [POS_W-1:0] p,
                                     input logic [POS_W-1:0] b,
                                     input logic [POS_W-1:0] e);
        in_zone = ($signed(p) >= $signed(b)) && ($signed(p) <= $signed(e));
    endfunction : in_zone

    logic mark_prev_q;
    logic mark_edge;
    logic mark_ok;
    assign mark_edge = mark_s & ~mark_prev_q;
    assign mark_ok = mark_edge &
        ~in_zone(actual_pos_i, ignore_zone_begin_i, ignore_zone_end_i);

    logic mark_seen_q;
    logic reached_q;
    logic [2:0] flags_q;
    logic set_end;
    assign set_end = (state_q == ST_RUN || state_q == ST_OFFSET ||
                      state_q == ST_SEARCH) && motion_done_i;

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            start_prev_q   <= 1'b0;
            mark_prev_q    <= 1'b0;
            set_q          <= HOMING_SET;
            state_q        <= ST_IDLE;
            homing_start_o <= 1'b0;
            move_start_o   <= 1'b0;
            mark_seen_q    <= 1'b0;
            mark_error_o   <= 1'b0;
        end
        else
        begin
            start_prev_q   <= ctrl_word1_i[CW1_START];
            mark_prev_q    <= mark_s;
            homing_start_o <= 1'b0;
            move_start_o   <= 1'b0;
            if (ack_o)
                mark_error_o <= 1'b0;
            unique case (state_q)
                ST_IDLE:
                begin
                    if (start_rise)
                    begin
                        set_q <= ctrl_word2_i[SW2_SET_LSB +: SET_W];
                        mark_seen_q <= 1'b0;
                        if (ctrl_word2_i[SW2_SET_LSB +: SET_W] == HOMING_SET)
                        begin
                            homing_start_o <= 1'b1;
                            state_q        <= ST_RUN;
                        end
                        else
                        begin
                            move_start_o <= 1'b1;
                            state_q      <= ST_RUN;
                        end
                    end
                end
                ST_RUN:
                begin
                    if (motion_done_i)
                        state_q <= ST_IDLE;
                    else if (func_cur == FN_SEARCH)
                        state_q <= ST_SEARCH;
                end
                ST_SEARCH:
                begin
                    if (motion_done_i)
                        state_q <= ST_IDLE;
                    else if (mark_ok)
                    begin
                        mark_seen_q  <= 1'b1;
                        set_q        <= next_set(set_q);
                        move_start_o <= 1'b1;
                        state_q      <= ST_OFFSET;
                        // permission belongs to the offset row, not the search row
                        if (decel_short_i && !table_q[next_set(set_q)][ROW_HIDEC_BIT])
                            mark_error_o <= 1'b1;
                    end
                end
                ST_OFFSET:
                begin
                    if (motion_done_i)
                        state_q <= ST_IDLE;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // flag update from the row that just ended
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            flags_q   <= 3'h0;
            reached_q <= 1'b0;
        end
        else
        begin
            if (move_start_o || homing_start_o)
                reached_q <= 1'b0;
            else if (set_end)
                reached_q <= 1'b1;
            if (set_end && set_q != HOMING_SET)
            begin
                for (int k = 0; k < 3; k++)
                begin
                    if (row_cur[ROW_FLAG_LSB + 2*k +: 2] == FLAG_CLR)
                        flags_q[k] <= 1'b0;
                    else if (row_cur[ROW_FLAG_LSB + 2*k +: 2] == FLAG_SET)
                        flags_q[k] <= 1'b1;
                end
            end
        end
    end

    // direction policy for modulo absolute moves
    logic [POS_W-1:0] ref_pos;
    logic [POS_W-1:0] tgt;
    logic [POS_W-1:0] fwd_dist;
    logic policy_on;
    logic [2:0] pol;
    assign tgt = row_cur[ROW_TGT_LSB +: POS_W];
    assign pol = row_cur[ROW_DIR_LSB +: 3];
    assign ref_pos = dynamic_pos_i ? brake_pos_i : actual_pos_i;
    assign fwd_dist = (tgt >= ref_pos) ? tgt - ref_pos : reset_dist_i - ref_pos + tgt;
    assign policy_on = (reset_dist_i != '0) && (func_cur == FN_ABS) &&
                       !tgt[POS_W-1] && (tgt < reset_dist_i) &&
                       !test_move_i && !post_homing_i;

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            move_func_o     <= 3'h0;
            move_target_o   <= '0;
            move_dir_neg_o  <= 1'b0;
            move_dir_free_o <= 1'b1;
            hi_decel_o      <= 1'b0;
        end
        else
        begin
            move_func_o   <= func_cur;
            move_target_o <= tgt;
            hi_decel_o    <= row_cur[ROW_HIDEC_BIT];
            move_dir_free_o <= 1'b1;
            move_dir_neg_o  <= 1'b0;
            if (policy_on)
            begin
                unique case (pol)
                    DIR_POS:   move_dir_free_o <= 1'b0;
                    DIR_NEG:
                    begin
                        move_dir_free_o <= 1'b0;
                        move_dir_neg_o  <= 1'b1;
                    end
                    DIR_SHORT:
                    begin
                        move_dir_free_o <= 1'b0; // exactly half distance goes positive
                        move_dir_neg_o  <= (fwd_dist > (reset_dist_i >> 1));
                    end
                    DIR_KEEP:
                    begin
                        move_dir_free_o <= 1'b0;
                        move_dir_neg_o  <= travel_dir_neg_i[0];
                    end
                    default:   move_dir_free_o <= 1'b1;
                endcase
            end
        end
    end

    // status words and mirrored outputs
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            status_word1_o          <= 16'h0000;
            status_word2_o          <= 16'h0000;
            no_error_output_o       <= 1'b0;
            target_reached_output_o <= 1'b0;
            held_at_zero_output_o   <= 1'b0;
            programmable_set_flags_o <= 3'h0;
        end
        else
        begin
            status_word1_o <= 16'h0000;
            status_word1_o[SW1_NO_ERROR]  <= ~fault_i & ~mark_error_o;
            status_word1_o[SW1_REACHED]   <= reached_q;
            status_word1_o[SW1_MARK_SEEN] <= mark_seen_q;
            status_word2_o <= {1'b0, flags_q, 7'h00, set_q};
            no_error_output_o       <= ~fault_i & ~mark_error_o;
            target_reached_output_o <= reached_q;
            held_at_zero_output_o   <= held_at_zero_i;
            programmable_set_flags_o <= flags_q;
        end
    end

    property p_guided_jog_off;
        @(posedge clk_i) disable iff (rst_i)
        ctrl_word1_i[CW1_GUIDE] |=> !jog_plus_o && !jog_minus_o;
    endproperty
    a_guided_jog_off: assert property (p_guided_jog_off)
        else $error("jog active while guided");

    property p_guided_energize;
        @(posedge clk_i) disable iff (rst_i)
        ctrl_word1_i[CW1_GUIDE] && !ctrl_word1_i[CW1_ENERGIZE] |=> !energize_o;
    endproperty
    a_guided_energize: assert property (p_guided_energize)
        else $error("energized without control bit");

    property p_homing;
        @(posedge clk_i) disable iff (rst_i)
        state_q == ST_IDLE && start_rise &&
        ctrl_word2_i[SW2_SET_LSB +: SET_W] == HOMING_SET |=> homing_start_o && !move_start_o;
    endproperty
    a_homing: assert property (p_homing)
        else $error("set zero did not start homing");

    property p_latch;
        @(posedge clk_i) disable iff (rst_i)
        state_q == ST_RUN && !start_rise |=> $stable(set_q) || state_q == ST_IDLE;
    endproperty
    a_latch: assert property (p_latch)
        else $error("set number changed while running");

    property p_mirror;
        @(posedge clk_i) disable iff (rst_i)
        ##1 target_reached_output_o == status_word1_o[SW1_REACHED] &&
            no_error_output_o == status_word1_o[SW1_NO_ERROR];
    endproperty
    a_mirror: assert property (p_mirror)
        else $error("outputs differ from status word");

    property p_unguided_stop;
        @(posedge clk_i) disable iff (rst_i)
        !ctrl_word1_i[CW1_GUIDE] |=> stop_o == !$past(stopin_s);
    endproperty
    a_unguided_stop: assert property (p_unguided_stop)
        else $error("stop does not follow input");

    property p_ignore;
        @(posedge clk_i) disable iff (rst_i)
        state_q == ST_SEARCH && mark_edge && !motion_done_i &&
        in_zone(actual_pos_i, ignore_zone_begin_i, ignore_zone_end_i) |=> state_q == ST_SEARCH;
    endproperty
    a_ignore: assert property (p_ignore)
        else $error("mark taken inside ignore window");

    property p_guided_stop;
        @(posedge clk_i) disable iff (rst_i)
        ctrl_word1_i[CW1_GUIDE] && !ctrl_word1_i[CW1_STOP_N] |=> stop_o;
    endproperty
    a_guided_stop: assert property (p_guided_stop)
        else $error("stop not held in guided mode");

endmodule : motion_set_sequencer

// ---- fieldbus_master_model.sv ----
// fieldbus master and discrete input model for the sequencer bench
`timescale 1ns/1ps
module fieldbus_master_model
(
    input  wire logic        clk_i,
    output logic [15:0]      cw1_o,
    output logic [15:0]      cw2_o,
    output logic [4:0]       pins_o
);
    // pins: 0 enable/ack, 1 no-stop, 2 jog plus, 3 jog minus, 4 mark
    initial
    begin
        cw1_o  = 16'h0000;
        cw2_o  = 16'h0000;
        pins_o = 5'h02;
    end
    task automatic put(input logic [15:0] cw1, input logic [4:0] pins);
        @(posedge clk_i);
        cw1_o  <= cw1;
        pins_o <= pins;
    endtask : put
    // set number moves on two cycles after start rises, as start drops, as a real master may
    task automatic start(input logic [4:0] set_no);
        @(posedge clk_i);
        cw1_o[6] <= 1'b1;
        cw2_o    <= {11'h000, set_no};
        repeat (2) @(posedge clk_i);
        cw1_o[6] <= 1'b0;
        cw2_o    <= {11'h000, ~set_no};
    endtask : start
endmodule : fieldbus_master_model

// ---- motion_set_sequencer_tb.sv ----
// self-checking bench for the motion set sequencer
`timescale 1ns/1ps
module motion_set_sequencer_tb
    import motion_set_pkg::*;
;
    logic             clk_i, rst_i, held, fault, done, tmove, phome, dyn, dshort, we;
    logic [15:0]      cw1, cw2, sw1, sw2;
    logic [4:0]       pins, taddr;
    logic [POS_W-1:0] apos, bpos, tdir, rdist, zb, ze, mtgt;
    logic [ROW_W-1:0] wdata;
    logic             energize, ack, stop, jogp, jogm, noerr, reached, hz;
    logic             hstart, mstart, dneg, dfree, hidec, merr;
    logic [2:0]       flags, mfunc;
    int               errors, checked, n_ack, n_ms, n_hs;

    fieldbus_master_model bm (.clk_i(clk_i), .cw1_o(cw1), .cw2_o(cw2), .pins_o(pins));

    motion_set_sequencer dut (.clk_i(clk_i), .rst_i(rst_i), .ctrl_word1_i(cw1),
        .ctrl_word2_i(cw2), .enable_ack_input_i(pins[0]), .stop_request_input_i(pins[1]),
        .jog_plus_input_i(pins[2]), .jog_minus_input_i(pins[3]), .mark_input_i(pins[4]),
        .held_at_zero_i(held), .fault_i(fault), .motion_done_i(done), .test_move_i(tmove),
        .post_homing_i(phome), .dynamic_pos_i(dyn), .actual_pos_i(apos), .brake_pos_i(bpos),
        .travel_dir_neg_i(tdir), .decel_short_i(dshort), .reset_dist_i(rdist),
        .ignore_zone_begin_i(zb), .ignore_zone_end_i(ze), .tbl_we_i(we), .tbl_addr_i(taddr),
        .tbl_wdata_i(wdata), .energize_o(energize), .ack_o(ack), .stop_o(stop),
        .jog_plus_o(jogp), .jog_minus_o(jogm), .no_error_output_o(noerr),
        .target_reached_output_o(reached), .held_at_zero_output_o(hz), .status_word1_o(sw1),
        .status_word2_o(sw2), .programmable_set_flags_o(flags), .homing_start_o(hstart),
        .move_start_o(mstart), .move_func_o(mfunc), .move_target_o(mtgt),
        .move_dir_neg_o(dneg), .move_dir_free_o(dfree), .hi_decel_o(hidec),
        .mark_error_o(merr));

    initial
    begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    // one-cycle pulses are counted here so no task can miss them
    always @(posedge clk_i)
    begin
        if (ack === 1'b1) n_ack++;
        if (mstart === 1'b1) n_ms++;
        if (hstart === 1'b1) n_hs++;
    end

    task automatic conclude();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : wait_cyc

    function automatic logic [ROW_W-1:0] row(input logic [31:0] t, input logic [2:0] f,
        input logic [5:0] fl, input logic [2:0] d, input logic h);
        return {3'h0, h, d, fl, f, t};
    endfunction : row

    task automatic put_row(input logic [4:0] a, input logic [ROW_W-1:0] r);
        @(posedge clk_i);
        we    <= 1'b1;
        taddr <= a;
        wdata <= r;
        @(posedge clk_i);
        we    <= 1'b0;
    endtask : put_row

    task automatic run(input logic [4:0] s);
        n_ms = 0;
        n_hs = 0;
        bm.start(s);
        wait_cyc(4);
    endtask : run

    task automatic end_set();
        @(posedge clk_i);
        done <= 1'b1;
        @(posedge clk_i);
        done <= 1'b0;
        wait_cyc(3);
    endtask : end_set

    task automatic t_status(input logic f, input logic h);
        fault <= f;
        held  <= h;
        wait_cyc(3);
        chk(noerr, sw1[SW1_NO_ERROR], "no error pin");
        chk(noerr, !f, "no error level");
        chk(hz, h, "held pin");
        chk(reached, sw1[SW1_REACHED], "reached pin");
    endtask : t_status

    task automatic t_guided();
        n_ack = 0;
        for (int k = 0; k < 8; k++)
        begin
            bm.put(16'h0400 | (k[1] ? 16'h0004 : 16'h0000)
                   | ((k[0] ^ k[1]) ? 16'h0010 : 16'h0000), {3'b011, k[2], k[0]});
            wait_cyc(5);
            chk(energize, k[0] & k[1], "energize");
            chk(stop, !(k[2] && (k[0] ^ k[1])), "stop");
            chk({jogp, jogm}, 2'b00, "jog");
        end
        chk(n_ack, 0, "pin ack");
        bm.put(16'h0494, 5'b00011);
        wait_cyc(4);
        chk(n_ack, 1, "word ack");
        $display("test guided done");
    endtask : t_guided

    task automatic t_unguided();
        bm.put(16'h0000, 5'b00000);
        wait_cyc(5);
        n_ack = 0;
        bm.put(16'h0080, 5'b00111);
        wait_cyc(5);
        chk({energize, stop, jogp, jogm}, 4'b1010, "pins plus");
        chk(n_ack, 1, "pin ack");
        bm.put(16'h0000, 5'b01001);
        wait_cyc(5);
        chk({energize, stop, jogp, jogm}, 4'b1101, "pins minus");
        t_status(1'b1, 1'b1);
        $display("test unguided done");
    endtask : t_unguided

    task automatic t_funcs();
        bm.put(16'h0414, 5'b00011);
        wait_cyc(5);
        t_status(1'b0, 1'b0);
        run(5'h00);
        chk(n_hs, 1, "homing");
        chk(n_ms, 0, "no move on homing");
        end_set();
        for (int f = 0; f < 7; f++)
        begin
            put_row(5'(11 + f), row(32'(f * 100), 3'(f), 6'h00, DIR_ANY, 1'b0));
            run(5'(11 + f));
            chk(n_ms, 1, "move start");
            chk(mfunc, f, "function");
            chk(sw2[4:0], 11 + f, "set number");
            chk(mtgt, f * 100, "latched target");
            end_set();
            end_set();
        end
        $display("test functions done");
    endtask : t_funcs

    task automatic t_dir();
        logic [2:0] pol [10] = '{DIR_POS, DIR_NEG, DIR_ANY, DIR_SHORT, DIR_SHORT,
                                 DIR_KEEP, DIR_NEG, DIR_NEG, DIR_NEG, DIR_NEG};
        // no shortest move spans exactly half the reset distance
        int tgt [10] = '{50, 50, 50, 50, 50, 50, 400, -5, 50, 50};
        int mode [10] = '{0, 0, 0, 0, 1, 0, 0, 0, 2, 4};
        int pos, fwd;
        logic efree, eneg;
        rdist <= 32'h0000_0168;
        apos  <= 32'h0000_0064;
        bpos  <= 32'h0000_012C;
        tdir  <= 32'h0000_0001;
        for (int i = 0; i < 10; i++)
        begin
            dyn   <= mode[i][0];
            tmove <= mode[i][1];
            phome <= mode[i][2];
            pos = mode[i][0] ? 300 : 100;
            fwd = (tgt[i] >= pos) ? tgt[i] - pos : tgt[i] + 360 - pos;
            efree = pol[i] == DIR_ANY || tgt[i] < 0 || tgt[i] >= 360 || mode[i] > 1;
            eneg = pol[i] == DIR_NEG || (pol[i] == DIR_SHORT && fwd > 180) || pol[i] == DIR_KEEP;
            put_row(5'(1 + i), row(tgt[i], FN_ABS, 6'h00, pol[i], 1'b0));
            run(5'(1 + i));
            chk(dfree, efree, "dir free");
            if (!efree) chk(dneg, eneg, "dir negative");
            end_set();
        end
        {dyn, tmove, phome} <= 3'b000;
        $display("test direction done");
    endtask : t_dir

    task automatic t_mark(input logic [4:0] s, input logic h);
        put_row(s, row(32'h0000_03E8, FN_SEARCH, 6'h00, DIR_ANY, 1'b0));
        put_row(s + 5'h01, row(32'h0000_0014, FN_REL, 6'h00, DIR_ANY, h));
        apos <= 32'hFFFF_FFCE;
        run(s);
        for (int j = 0; j < 2; j++)
        begin
            bm.put(16'h0414, 5'b10011);
            wait_cyc(2);
            bm.put(16'h0414, 5'b00011);
            wait_cyc(6);
            chk(sw1[SW1_MARK_SEEN], j, "mark seen");
            apos <= 32'h0000_00C8;
        end
        chk(merr, !h, "offset error");
        chk(hidec, h, "higher decel");
        end_set();
        end_set();
        bm.put(16'h0494, 5'b00011);
        bm.put(16'h0414, 5'b00011);
        wait_cyc(4);
        chk(merr, 1'b0, "error cleared");
    endtask : t_mark

    task automatic t_flags();
        put_row(5'h18, row(32'h0000_0010, FN_REL, 6'b01_01_01, DIR_ANY, 1'b0));
        put_row(5'h19, row(32'h0000_0020, FN_REL, 6'b00_10_11, DIR_ANY, 1'b0));
        run(5'h18);
        end_set();
        chk(flags, 3'b111, "flags set");
        chk(sw2[14:12], 3'b111, "status flags");
        run(5'h19);
        n_ms = 0;
        run(5'h1A);
        chk(n_ms, 0, "start refused");
        chk(sw2[4:0], 5'h19, "set kept");
        end_set();
        chk(flags, 3'b101, "flags mixed");
        chk(sw2[14:12], 3'b101, "status mixed");
        chk(reached, sw1[SW1_REACHED], "reached pin");
        $display("test flags done");
    endtask : t_flags

    initial
    begin
        #400000;
        errors++;
        conclude();
    end

    initial
    begin
        {rst_i, held, fault, done, tmove, phome, dyn, dshort, we} = 9'h100;
        {apos, bpos, tdir, rdist} = '0;
        zb = 32'hFFFF_FF9C;
        ze = 32'h0000_0064;
        taddr = 5'h00;
        wdata = '0;
        wait_cyc(5);
        chk({stop, dfree, energize}, 3'b110, "reset levels");
        wait_cyc(5);
        rst_i <= 1'b0;
        wait_cyc(2);
        t_guided();
        t_unguided();
        t_funcs();
        t_dir();
        dshort <= 1'b1;
        t_mark(5'h14, 1'b0);
        t_mark(5'h16, 1'b1);
        $display("test mark done");
        t_flags();
        conclude();
    end
endmodule : motion_set_sequencer_tb
